// File: stpc_pkg.sv
// Package: constants shared by the serial-to-parallel capture block
package stpc_pkg;
	// ==========================================================
	// Word layout
	localparam int STAGE_BITS = 8;
	localparam int WORD_BITS  = 16;
	// ==========================================================
	// Reset values
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0]  STAGE_RESET = 8'h00;
	// Frame sync idles high, as the flag does between words
	localparam logic [2:0]  FRAME_SYNC_IDLE = 3'h7;
	localparam logic        DRIVE_RESET     = 1'b1;
	// ==========================================================
	// Buffer
	localparam int FIFO_DEPTH = 16;
	// ==========================================================
	// Clocking modes of the converter (context for the mode select pins)
	typedef enum logic [1:0] {
		STPC_PLL_CLOCK_MODE_ONE,
		STPC_PLL_CLOCK_MODE_TWO,
		STPC_CLOCK_OVERRIDE_MODE
	} stpc_clk_mode_type;
endpackage

// File: stpc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stpc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	logic             push;
	logic             pop;
	assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
	assign out_valid = wr_reg != rd_reg;
	assign out_data  = mem[rd_reg[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end
endmodule
`default_nettype wire

// File: stpc_capture.sv
// Top: serial sample capture into latched 16-bit words with handshake
// Notes on behaviour
// R1 - Bits are shifted in on the falling edge of the serial bit clock.
// R2 - Word is two cascaded 8-bit shift stages, each with a holding latch.
// R3 - Frame flag rising edge copies shift contents into output latches.
// R4 - Same frame flag rising edge sets the word-ready flag.
// R5 - Word-ready is presented whenever a new word has been latched.
// R6 - Reader acknowledges a taken word; acknowledge clears word-ready.
// R7 - System picks a clocking mode setting sample and word rate.
// R8 - PLL modes multiply master clock; override mode bypasses the PLL.
// R9 - Output enable and phase reset may be driven by an outside controller.
// R10 - Converter sends MSB first, changing data on bit clock rising edge.
// R11 - Frame flag low marks valid bits; bit clock runs freely.
// R12 - Output enable high floats data, frame flag and bit clock; the converter model drives them inverted instead.
// R13 - Output latches hold the last word until the next frame rising edge.
`timescale 1ns/1ps
`default_nettype none
module stpc_capture
	import stpc_pkg::*;
#(
	parameter int FIFO_DEPTH_P = stpc_pkg::FIFO_DEPTH
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rst_b,
	input  wire logic                       serial_bit_clock,
	input  wire logic                       serial_data,
	input  wire logic                       word_frame_flag,
	input  wire logic                       word_acknowledge,
	input  wire logic                       fifo_out_ready,
	output logic [stpc_pkg::WORD_BITS-1:0]  parallel_word,
	output logic                            word_ready_flag,
	output logic [stpc_pkg::WORD_BITS-1:0]  fifo_out_data,
	output logic                            fifo_out_valid,
	output logic                            word_overrun,
	output logic                            output_drive_enable_b
);
	import stpc_pkg::*;
	// ==========================================================
	// State
	typedef struct packed {
		logic [2:0]            clk_sync;
		logic [1:0]            dat_sync;
		logic [2:0]            frm_sync;
		logic [1:0]            ack_sync;
		logic [STAGE_BITS-1:0] stage_hi;
		logic [STAGE_BITS-1:0] stage_lo;
		logic [STAGE_BITS-1:0] latch_hi;
		logic [STAGE_BITS-1:0] latch_lo;
		logic                  ready;
		logic                  push;
		logic                  overrun;
		logic [WORD_BITS-1:0]  fifo_out;
		logic                  fifo_vld;
		logic                  drive_b;
	} stpc_state_type;
	stpc_state_type state_reg;
	stpc_state_type state_next;
	// Frame sync starts idle high, so leaving reset is never a word end
	localparam stpc_state_type STATE_RESET = '{
		frm_sync: FRAME_SYNC_IDLE,
		drive_b:  DRIVE_RESET,
		default:  '0
	};
	logic                 fall_bit;
	logic                 rise_frame;
	logic                 fifo_in_ready;
	logic [WORD_BITS-1:0] fifo_q;
	logic                 fifo_q_valid;
	logic                 fifo_pop;
	// Only the second and third sync stages feed edge detection
	assign fall_bit   = state_reg.clk_sync[2] && !state_reg.clk_sync[1];
	assign rise_frame = !state_reg.frm_sync[2] && state_reg.frm_sync[1];
	assign fifo_pop   = fifo_q_valid && (!state_reg.fifo_vld || fifo_out_ready);
	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		// Bit rate follows the converter's clock mode; only edges count, see R8
		state_next.clk_sync = {state_reg.clk_sync[1:0], serial_bit_clock};
		state_next.dat_sync = {state_reg.dat_sync[0], serial_data};
		// The floating frame flag is ignored: turning the drivers on
		// must not look like the end of a word
		if (state_reg.drive_b) begin // see R12
			state_next.frm_sync = FRAME_SYNC_IDLE;
		end else begin
			state_next.frm_sync = {state_reg.frm_sync[1:0], word_frame_flag};
		end
		state_next.ack_sync = {state_reg.ack_sync[0], word_acknowledge};
		state_next.drive_b = 1'b0; // see R9, R12
		state_next.push = 1'b0;
		// Bits outside the frame are shifted too; the frame edge picks
		// the last sixteen, as the free-running clock requires
		if (fall_bit) begin // see R1
			// Low stage overflows into the high stage, MSB ends up on top
			state_next.stage_hi = {state_reg.stage_hi[STAGE_BITS-2:0],
				state_reg.stage_lo[STAGE_BITS-1]}; // see R2
			state_next.stage_lo = {state_reg.stage_lo[STAGE_BITS-2:0],
				state_reg.dat_sync[1]}; // see R2
		end
		// Latches change only here, so shifting never disturbs them
		if (rise_frame) begin // see R13
			state_next.latch_hi = state_reg.stage_hi; // see R3
			state_next.latch_lo = state_reg.stage_lo; // see R3
			state_next.push     = 1'b1;
		end
		// Set beats a simultaneous acknowledge so no word is missed
		if (rise_frame) begin
			state_next.ready = 1'b1; // see R4
		end else if (state_reg.ack_sync[1]) begin
			state_next.ready = 1'b0; // see R6
		end
		// Full FIFO drops the word and flags it; sticky until reset
		if (state_reg.push && !fifo_in_ready) begin
			state_next.overrun = 1'b1;
		end
		if (fifo_pop) begin
			state_next.fifo_out = fifo_q;
			state_next.fifo_vld = 1'b1;
		end else if (fifo_out_ready) begin
			state_next.fifo_vld = 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end
	// ==========================================================
	// Buffer behind the latches
	stpc_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (FIFO_DEPTH_P)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.in_data   ({state_reg.latch_hi, state_reg.latch_lo}),
		.in_valid  (state_reg.push),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_q),
		.out_valid (fifo_q_valid),
		.out_ready (fifo_pop)
	);
	assign parallel_word   = {state_reg.latch_hi, state_reg.latch_lo};
	assign word_ready_flag = state_reg.ready; // see R5
	assign fifo_out_data   = state_reg.fifo_out;
	assign fifo_out_valid  = state_reg.fifo_vld;
	assign word_overrun    = state_reg.overrun;
	assign output_drive_enable_b = state_reg.drive_b; // see R9, R12
	// ==========================================================
	// Checks
	property p_ready_set;
		@(posedge sys_clk) disable iff (!rst_b)
		rise_frame |=> word_ready_flag;
	endproperty
	a_ready_set: assert property (p_ready_set) // see R4
		else $error("frame edge did not set ready");
	c_ack_seen: cover property (@(posedge sys_clk) disable iff (!rst_b)
		rise_frame ##[1:40] state_reg.ack_sync[1]);
	property p_latch_copy;
		@(posedge sys_clk) disable iff (!rst_b)
		rise_frame |=> parallel_word == $past({state_reg.stage_hi,
			state_reg.stage_lo});
	endproperty
	a_latch_copy: assert property (p_latch_copy) // see R3
		else $error("latch did not copy shift stages");
	property p_latch_hold;
		@(posedge sys_clk) disable iff (!rst_b)
		!rise_frame |=> $stable(parallel_word);
	endproperty
	a_latch_hold: assert property (p_latch_hold) // see R13
		else $error("latch changed without frame edge");
	property p_ack_clear;
		@(posedge sys_clk) disable iff (!rst_b)
		state_reg.ack_sync[1] && !rise_frame |=> !word_ready_flag;
	endproperty
	a_ack_clear: assert property (p_ack_clear) // see R6
		else $error("acknowledge did not clear ready");
	property p_ready_cause;
		@(posedge sys_clk) disable iff (!rst_b)
		$rose(word_ready_flag) |-> $past(rise_frame);
	endproperty
	a_ready_cause: assert property (p_ready_cause) // see R5
		else $error("ready rose without a frame edge");
	property p_shift_fall;
		@(posedge sys_clk) disable iff (!rst_b)
		fall_bit |=> state_reg.stage_lo[0] == $past(state_reg.dat_sync[1]);
	endproperty
	a_shift_fall: assert property (p_shift_fall) // see R1
		else $error("bit not taken on falling clock");
	property p_cascade;
		@(posedge sys_clk) disable iff (!rst_b)
		fall_bit |=> state_reg.stage_hi[0] == $past(state_reg.stage_lo[7]);
	endproperty
	a_cascade: assert property (p_cascade) // see R2
		else $error("stages not cascaded");
	property p_no_shift;
		@(posedge sys_clk) disable iff (!rst_b)
		!fall_bit |=> $stable(state_reg.stage_lo) && $stable(state_reg.stage_hi);
	endproperty
	a_no_shift: assert property (p_no_shift) // see R1
		else $error("shift without falling clock");
	property p_drive;
		@(posedge sys_clk) disable iff (!rst_b)
		rst_b ##1 rst_b |-> !output_drive_enable_b;
	endproperty
	a_drive: assert property (p_drive) // see R12
		else $error("outputs not enabled after reset");
	c_word: cover property (@(posedge sys_clk) disable iff (!rst_b)
		rise_frame ##1 word_ready_flag);
	c_overrun: cover property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(word_overrun));
	c_fifo_out: cover property (@(posedge sys_clk) disable iff (!rst_b)
		fifo_out_valid && fifo_out_ready);
	// ==========================================================
	// Checks: word hand-over and high stage shift
	property p_push_follow;
		@(posedge sys_clk) disable iff (!rst_b)
		rise_frame |=> state_reg.push;
	endproperty
	a_push_follow: assert property (p_push_follow) // see R3
		else $error("latched word not handed to the buffer");
	property p_push_cause;
		@(posedge sys_clk) disable iff (!rst_b)
		state_reg.push |-> $past(rise_frame);
	endproperty
	a_push_cause: assert property (p_push_cause) // see R3
		else $error("buffer push without a frame edge");
	property p_stage_hi_shift;
		@(posedge sys_clk) disable iff (!rst_b)
		fall_bit |=> state_reg.stage_hi[STAGE_BITS-1:1] ==
			$past(state_reg.stage_hi[STAGE_BITS-2:0]);
	endproperty
	a_stage_hi_shift: assert property (p_stage_hi_shift) // see R2
		else $error("high stage did not shift");
	property p_ready_hold;
		@(posedge sys_clk) disable iff (!rst_b)
		word_ready_flag && !state_reg.ack_sync[1] |=> word_ready_flag;
	endproperty
	a_ready_hold: assert property (p_ready_hold) // see R5
		else $error("ready dropped without acknowledge");
	property p_ready_fall;
		@(posedge sys_clk) disable iff (!rst_b)
		$fell(word_ready_flag) |-> $past(state_reg.ack_sync[1]);
	endproperty
	a_ready_fall: assert property (p_ready_fall) // see R6
		else $error("ready fell without acknowledge");
	property p_ready_reset;
		@(posedge sys_clk)
		!rst_b |=> !word_ready_flag;
	endproperty
	a_ready_reset: assert property (p_ready_reset) // see R5
		else $error("ready set while in reset");
	// ==========================================================
	// Checks: buffer and overrun
	// Overrun is sticky so a reader that polls late still learns of a loss
	property p_overrun_set;
		@(posedge sys_clk) disable iff (!rst_b)
		state_reg.push && !fifo_in_ready |=> word_overrun;
	endproperty
	a_overrun_set: assert property (p_overrun_set)
		else $error("dropped word not flagged");
	property p_overrun_sticky;
		@(posedge sys_clk) disable iff (!rst_b)
		word_overrun |=> word_overrun;
	endproperty
	a_overrun_sticky: assert property (p_overrun_sticky)
		else $error("overrun flag cleared");
	property p_overrun_cause;
		@(posedge sys_clk) disable iff (!rst_b)
		$rose(word_overrun) |-> $past(state_reg.push) && !$past(fifo_in_ready);
	endproperty
	a_overrun_cause: assert property (p_overrun_cause)
		else $error("overrun without a dropped word");
	property p_out_hold;
		@(posedge sys_clk) disable iff (!rst_b)
		fifo_out_valid && !fifo_out_ready |=>
			fifo_out_valid && $stable(fifo_out_data);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("buffered word changed before it was taken");
	property p_out_load;
		@(posedge sys_clk) disable iff (!rst_b)
		fifo_pop |=> fifo_out_valid && fifo_out_data == $past(fifo_q);
	endproperty
	a_out_load: assert property (p_out_load)
		else $error("buffered word not loaded");
	// ==========================================================
	// Checks: converter drive
	property p_drive_stays;
		@(posedge sys_clk) disable iff (!rst_b)
		!output_drive_enable_b |=> !output_drive_enable_b;
	endproperty
	a_drive_stays: assert property (p_drive_stays) // see R12
		else $error("converter drive dropped");
	property p_drive_reset;
		@(posedge sys_clk)
		!rst_b |=> output_drive_enable_b;
	endproperty
	a_drive_reset: assert property (p_drive_reset) // see R12
		else $error("converter driven while in reset");
	property p_frame_idle;
		@(posedge sys_clk) disable iff (!rst_b)
		output_drive_enable_b |=> state_reg.frm_sync == FRAME_SYNC_IDLE;
	endproperty
	a_frame_idle: assert property (p_frame_idle) // see R12
		else $error("floating frame flag not held idle");
	property p_no_edge_released;
		@(posedge sys_clk) disable iff (!rst_b)
		output_drive_enable_b |-> !rise_frame;
	endproperty
	a_no_edge_released: assert property (p_no_edge_released) // see R12
		else $error("frame edge seen while converter floats");
endmodule
`default_nettype wire

// File: stpc_conv_model.sv
// Converter serial output model: free-running bit clock, framed words
`timescale 1ns/1ps
`default_nettype none
module stpc_conv_model (
	input  wire logic output_drive_enable_b,
	output logic      serial_bit_clock,
	output logic      serial_data,
	output logic      word_frame_flag
);
	logic bclk_reg;
	logic data_reg;
	logic frame_reg;
	// ==========================================================
	// Free-running 200 ns bit clock: one fixed clock mode
	initial begin
		bclk_reg = 1'b0;
		data_reg = 1'b0;
		frame_reg = 1'b1;
		forever #100 bclk_reg = ~bclk_reg;
	end
	// The enable comes from the block as outside controller
	// Released lines show the inverse, so a stale value never passes
	assign serial_bit_clock = output_drive_enable_b ? ~bclk_reg : bclk_reg;
	assign serial_data      = output_drive_enable_b ? ~data_reg : data_reg;
	assign word_frame_flag  = output_drive_enable_b ? ~frame_reg : frame_reg;
	// ==========================================================
	// One word: data moves on the rising edge, frame low around it
	task automatic send_word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			@(posedge bclk_reg);
			frame_reg <= 1'b0;
			data_reg <= w[i];
		end
		@(posedge bclk_reg);
		frame_reg <= 1'b1;
		data_reg <= ~w[0];
	endtask
endmodule
`default_nettype wire

// File: stpc_capture_tb.sv
// Self-checking bench for the serial capture block
`timescale 1ns/1ps
`default_nettype none
module stpc_capture_tb;
	import stpc_pkg::*;
	localparam int DEPTH = 4;
	logic        sys_clk;
	logic        rst_b;
	logic        serial_bit_clock;
	logic        serial_data;
	logic        word_frame_flag;
	logic        word_acknowledge;
	logic        fifo_out_ready;
	logic [15:0] parallel_word;
	logic        word_ready_flag;
	logic [15:0] fifo_out_data;
	logic        fifo_out_valid;
	logic        word_overrun;
	logic        output_drive_enable_b;
	int          failures = 0;
	int          n_tests = 0;
	logic [15:0] wtab [6] = '{16'h8001, 16'h7FFE, 16'hFFFF,
		16'h0001, 16'h1234, 16'hC3A5};

	stpc_conv_model u_conv (.output_drive_enable_b(output_drive_enable_b),
		.serial_bit_clock(serial_bit_clock), .serial_data(serial_data),
		.word_frame_flag(word_frame_flag));
	stpc_capture #(.FIFO_DEPTH_P(DEPTH)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.serial_bit_clock(serial_bit_clock), .serial_data(serial_data),
		.word_frame_flag(word_frame_flag), .word_acknowledge(word_acknowledge),
		.fifo_out_ready(fifo_out_ready), .parallel_word(parallel_word),
		.word_ready_flag(word_ready_flag), .fifo_out_data(fifo_out_data),
		.fifo_out_valid(fifo_out_valid), .word_overrun(word_overrun),
		.output_drive_enable_b(output_drive_enable_b));

	// ==========================================================
	// Shared helpers
	task automatic final_report();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask
	// Old word must stand while the next one shifts in
	task automatic wait_ready(input logic [15:0] hold);
		int i;
		i = 0;
		while (word_ready_flag !== 1'b1 && i < 600) begin
			@(negedge sys_clk);
			if (word_ready_flag !== 1'b1 && parallel_word !== hold) begin
				chk("held word", hold, parallel_word);
			end
			i++;
		end
		if (i >= 600) begin
			failures++;
			final_report();
		end
	endtask
	task automatic send_chk(input logic [15:0] w, input logic [15:0] hold);
		fork
			u_conv.send_word(w);
			wait_ready(hold);
		join
		chk("parallel_word", w, parallel_word);
		chk("word_ready_flag", 16'(1), 16'(word_ready_flag));
	endtask
	task automatic do_ack();
		int i;
		@(posedge sys_clk);
		word_acknowledge <= 1'b1;
		@(negedge sys_clk);
		chk("ready before sync", 16'(1), 16'(word_ready_flag));
		i = 0;
		while (word_ready_flag !== 1'b0 && i < 6) begin
			@(negedge sys_clk);
			i++;
		end
		chk("ready after ack", 16'(0), 16'(word_ready_flag));
		if (i >= 6) final_report();
		@(posedge sys_clk);
		word_acknowledge <= 1'b0;
	endtask
	task automatic drain_one(input logic [15:0] e);
		int i;
		i = 0;
		while (fifo_out_valid !== 1'b1 && i < 400) begin
			@(negedge sys_clk);
			i++;
		end
		if (i >= 400) begin
			failures++;
			final_report();
		end
		chk("fifo_out_data", e, fifo_out_data);
		@(posedge sys_clk);
		fifo_out_ready <= 1'b1;
		@(posedge sys_clk);
		fifo_out_ready <= 1'b0;
		@(negedge sys_clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		@(negedge sys_clk);
		chk("drive enable in reset", 16'(1), 16'(output_drive_enable_b));
		chk("parallel_word reset", 16'h0000, parallel_word);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("drive enable", 16'(0), 16'(output_drive_enable_b));
		// Turning the drivers on must not pass for a finished word
		repeat (8) @(negedge sys_clk);
		chk("ready after reset", 16'(0), 16'(word_ready_flag));
		chk("no word after reset", 16'h0000, parallel_word);
		$display("t_reset done");
	endtask
	task automatic t_words();
		send_chk(16'hA53C, 16'h0000);
		do_ack();
		send_chk(16'h5A0F, 16'hA53C);
		do_ack();
		drain_one(16'hA53C);
		drain_one(16'h5A0F);
		$display("t_words done");
	endtask
	// Reader stalls: the output register holds one word beyond the depth,
	// so the second word past the depth is dropped and flagged
	task automatic t_overrun();
		logic [15:0] prev;
		prev = 16'h5A0F;
		for (int k = 0; k <= DEPTH + 1; k++) begin
			if (k == DEPTH + 1) chk("no overrun yet", 16'(0), 16'(word_overrun));
			send_chk(wtab[k], prev);
			do_ack();
			prev = wtab[k];
		end
		repeat (4) @(negedge sys_clk);
		chk("word_overrun", 16'(1), 16'(word_overrun));
		for (int k = 0; k <= DEPTH; k++) drain_one(wtab[k]);
		chk("fifo empty", 16'(0), 16'(fifo_out_valid));
		$display("t_overrun done");
	endtask

	// ==========================================================
	// Clock, reset, sequence and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		rst_b = 1'b0;
		word_acknowledge = 1'b0;
		fifo_out_ready = 1'b0;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset();
		t_words();
		t_overrun();
		final_report();
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		failures++;
		final_report();
	end
endmodule
`default_nettype wire
